// file: hw/spm_core.sv
// SPI mode synchronous serial port: shift register, buffer, flags and pin control.
// Assumes pins arrive asynchronously and software strobes are one-cycle pulses on sys_clk.
`timescale 1ns/1ns
`default_nettype none
module spm_core #(
  parameter int SS_RESET_CYCLES = spm_pkg::SS_RESET_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire spm_pkg::spm_ctrl_t ctrl,
  input wire spm_pkg::spm_dir_t dirBits,
  input wire logic bufWrite,
  input wire logic [7:0] bufWriteData,
  input wire logic bufRead,
  output logic [7:0] bufReadData,
  input wire logic collisionClear,
  input wire logic irqClear,
  input wire logic timerTick,
  output logic writeCollisionFlag,
  output logic bufferFullFlag,
  output logic portIrqFlag,
  output logic wakeRequest,
  output logic portActive,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic sdiIn,
  output logic sdoOut,
  output logic sdoOe,
  input wire logic ssNIn
);
  import spm_pkg::*;

  logic [2:0] pinMeta;
  logic [2:0] pinSync;
  logic sckPin, sdiPin, ssNPin, sckPrevAct;
  logic isMaster, isSlave, selectCtl, deselected, monitorMode, sdiBit;
  logic masterBusy, sckPhase, next_sckPhase, halfTick, busy;
  logic [3:0] halfCount;
  logic [3:0] bitCount;
  logic [7:0] shiftReg;
  logic [7:0] ssHighCount;
  logic ssReset, sckAct;
  logic masterLead, masterTrail, slaveLead, slaveTrail, leadEdge, trailEdge;
  logic sampleEdge, launchEdge, byteDone, writeAccepted, collision;
  logic [1:0] catchPipe;
  logic masterCatch;
  logic [7:0] rxWord;
  spm_rate_t rate;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pinMeta <= 3'h0;
      pinSync <= 3'h0;
    end else begin
      pinMeta <= {sckIn, sdiIn, ssNIn};
      pinSync <= pinMeta;
    end
  end
  assign sckPin = pinSync[2];
  assign sdiPin = pinSync[1];
  assign ssNPin = pinSync[0];

  assign portActive = ctrl.enable;
  assign isMaster = ctrl.enable && (ctrl.modeField <= MODE_MASTER_TIMER);
  assign isSlave = ctrl.enable
                && (ctrl.modeField == MODE_SLAVE_SELECT || ctrl.modeField == MODE_SLAVE_FREE);
  assign selectCtl = isSlave && ctrl.modeField == MODE_SLAVE_SELECT && dirBits.portaDir5;
  assign deselected = selectCtl && ssNPin;
  assign monitorMode = isMaster && dirBits.portcDir3;
  assign sdiBit = dirBits.portcDir4 ? sdiPin : 1'b0;
  assign rate = spm_rate_t'(ctrl.modeField[1:0]);

  spm_rate_gen u_rate (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .run(isMaster && masterBusy),
    .rate(rate),
    .timerTick(timerTick),
    .halfTick(halfTick)
  );

  // Master clock: sixteen half periods per byte, phase 1 is the active level.
  assign masterLead = halfTick && !sckPhase;
  assign masterTrail = halfTick && sckPhase;
  assign next_sckPhase = !masterBusy ? 1'b0 : (halfTick ? !sckPhase : sckPhase);

  always_ff @(posedge sys_clk) begin
    if (!resetn || !isMaster) begin
      masterBusy <= 1'b0;
    end else if (writeAccepted || (monitorMode && !masterBusy)) begin
      masterBusy <= 1'b1;
    end else if (masterTrail && halfCount == HALF_LAST) begin
      masterBusy <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || !masterBusy) begin
      halfCount <= 4'h0;
    end else if (halfTick) begin
      halfCount <= halfCount + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sckPhase <= 1'b0;
      sckOut <= 1'b0;
    end else begin
      sckPhase <= next_sckPhase;
      sckOut <= ctrl.idlePolarity ^ next_sckPhase;
    end
  end

  // Slave clock edges come from the synchronised pin, relative to the idle level.
  assign sckAct = sckPin ^ ctrl.idlePolarity;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sckPrevAct <= 1'b0;
    end else begin
      sckPrevAct <= sckAct;
    end
  end
  // Slave edges are found by sys_clk registers, so the slave logic only runs while the core clock runs.
  assign slaveLead = isSlave && dirBits.portcDir3 && !deselected && sckAct && !sckPrevAct;
  assign slaveTrail = isSlave && dirBits.portcDir3 && !deselected && !sckAct && sckPrevAct;

  assign leadEdge = isMaster ? masterLead : slaveLead;
  assign trailEdge = isMaster ? masterTrail : slaveTrail;
  assign sampleEdge = ctrl.edgeSelect ? leadEdge : trailEdge;
  assign launchEdge = ctrl.edgeSelect ? trailEdge : leadEdge;
  // The pin synchroniser delays data-in by two clocks, so the master takes each bit two
  // clocks after its own sample edge, while the far side still holds it.
  always_ff @(posedge sys_clk) begin
    if (!resetn || !isMaster) begin
      catchPipe <= 2'h0;
    end else begin
      catchPipe <= {catchPipe[0], sampleEdge};
    end
  end
  assign masterCatch = catchPipe[1];
  assign byteDone = isMaster ? (masterCatch && bitCount == 4'(BYTE_BITS))
                             : (sampleEdge && bitCount == BIT_LAST);
  assign rxWord = isMaster ? {shiftReg[7:1], sdiBit} : {shiftReg[6:0], sdiBit};

  assign busy = isMaster ? (masterBusy || bitCount != 4'h0) : (bitCount != 4'h0);
  assign writeAccepted = bufWrite && ctrl.enable && !busy;
  assign collision = bufWrite && ctrl.enable && busy;

  // Select held high for the reset time clears the bit position.
  always_ff @(posedge sys_clk) begin
    if (!resetn || !deselected) begin
      ssHighCount <= 8'h00;
    end else if (!ssReset) begin
      ssHighCount <= ssHighCount + 8'h01;
    end
  end
  assign ssReset = ssHighCount == 8'(SS_RESET_CYCLES - 1);

  always_ff @(posedge sys_clk) begin
    if (!resetn || !ctrl.enable || ssReset || byteDone) begin
      bitCount <= 4'h0;
    end else if (sampleEdge) begin
      bitCount <= bitCount + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      shiftReg <= 8'h00;
    end else if (writeAccepted) begin
      shiftReg <= bufWriteData;
    end else if (sampleEdge) begin
      shiftReg <= {shiftReg[6:0], isMaster ? 1'b0 : sdiBit};
    end else if (masterCatch) begin
      shiftReg[0] <= sdiBit;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sdoOut <= 1'b0;
    end else if (writeAccepted && ctrl.edgeSelect) begin
      sdoOut <= bufWriteData[7];
    end else if (launchEdge) begin
      sdoOut <= shiftReg[7];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bufReadData <= 8'h00;
    end else if (writeAccepted) begin
      bufReadData <= bufWriteData;
    end else if (byteDone) begin
      bufReadData <= rxWord;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      writeCollisionFlag <= 1'b0;
    end else if (collision) begin
      writeCollisionFlag <= 1'b1;
    end else if (collisionClear) begin
      writeCollisionFlag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bufferFullFlag <= 1'b0;
    end else if (byteDone) begin
      bufferFullFlag <= 1'b1;
    end else if (bufRead) begin
      bufferFullFlag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      portIrqFlag <= 1'b0;
    end else if (byteDone) begin
      portIrqFlag <= 1'b1;
    end else if (irqClear) begin
      portIrqFlag <= 1'b0;
    end
  end

  assign wakeRequest = portIrqFlag;
  assign sckOe = isMaster && !dirBits.portcDir3;
  assign sdoOe = ctrl.enable && !dirBits.portcDir5 && !deselected;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_masterStart;
    $rose(masterBusy) && ctrl.modeField == MODE_MASTER_DIV4 && !monitorMode;
  endsequence

  property p_collision;
    collision |=> writeCollisionFlag && ($stable(shiftReg) || $past(sampleEdge || masterCatch));
  endproperty
  a_collision: assert property (p_collision) else $error("Write collision not flagged.");

  property p_writeStarts;
    bufWrite && isMaster && !busy |=> masterBusy && bufReadData == $past(bufWriteData);
  endproperty
  a_writeStarts: assert property (p_writeStarts) else $error("Master write did not start.");

  property p_byteDone;
    byteDone |=> bufferFullFlag && portIrqFlag && bufReadData == $past(rxWord);
  endproperty
  a_byteDone: assert property (p_byteDone) else $error("Completed byte not posted.");

  property p_readClears;
    bufRead && !byteDone |=> !bufferFullFlag;
  endproperty
  a_readClears: assert property (p_readClears) else $error("Buffer read left full flag set.");

  property p_release;
    selectCtl && ssNPin |-> !sdoOe;
  endproperty
  a_release: assert property (p_release) else $error("Data-out driven while deselected.");

  property p_disabled;
    !ctrl.enable |-> !sckOe && !sdoOe && !busy;
  endproperty
  a_disabled: assert property (p_disabled) else $error("Disabled port is active.");

  property p_twoWire;
    dirBits.portcDir5 |-> !sdoOe;
  endproperty
  a_twoWire: assert property (p_twoWire) else $error("Data-out driven as input.");

  property p_masterLength;
    s_masterStart |-> masterBusy[*8] ##1 (masterBusy || !isMaster);
  endproperty
  a_masterLength: assert property (p_masterLength) else $error("Master byte ended early.");

  property p_div4Half;
    halfTick && rate == RATE_DIV4 && masterBusy && $stable(ctrl) |=> !halfTick;
  endproperty
  a_div4Half: assert property (p_div4Half) else $error("Divide-by-4 half period wrong.");

  property p_idleLevel;
    !masterBusy && $past(!masterBusy) && $stable(ctrl.idlePolarity) |-> sckOut == ctrl.idlePolarity;
  endproperty
  a_idleLevel: assert property (p_idleLevel) else $error("Clock not at idle level.");

  property p_resume;
    deselected && !ssReset && ctrl.enable |=> $stable(bitCount);
  endproperty
  a_resume: assert property (p_resume) else $error("Bit position lost while deselected.");

  property p_ssReset;
    ssReset |=> bitCount == 4'h0;
  endproperty
  a_ssReset: assert property (p_ssReset) else $error("Select high did not reset transfer.");

endmodule
`default_nettype wire

// file: hw/spm_pkg.sv
// Shared constants and types for the SPI mode serial port.
// Assumes a single 100 MHz core clock; sys_clk stands in for the oscillator clock.
package spm_pkg;

  localparam int BYTE_BITS = 8;

  // Mode field codes.
  localparam logic [3:0] MODE_MASTER_DIV4 = 4'h0;
  localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
  localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
  localparam logic [3:0] MODE_MASTER_TIMER = 4'h3;
  localparam logic [3:0] MODE_SLAVE_SELECT = 4'h4;
  localparam logic [3:0] MODE_SLAVE_FREE = 4'h5;

  // Half bit periods in core clocks for the divided rates.
  localparam logic [5:0] HALF_DIV4 = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;

  // A master byte is sixteen clock half periods.
  localparam logic [3:0] HALF_LAST = 4'hF;
  localparam logic [3:0] BIT_LAST = 4'h7;

  // Core clocks that the select pin must stay high before the transfer logic resets.
  localparam int SS_RESET_DEFAULT = 16;

  typedef enum logic [1:0] {RATE_DIV4, RATE_DIV16, RATE_DIV64, RATE_TIMER} spm_rate_t;

  typedef struct packed {
    logic enable;
    logic idlePolarity;
    logic edgeSelect;
    logic [3:0] modeField;
  } spm_ctrl_t;

  typedef struct packed {
    logic portcDir3;
    logic portcDir4;
    logic portcDir5;
    logic portaDir5;
  } spm_dir_t;

endpackage

// file: hw/spm_rate_gen.sv
// Master bit clock half-period strobe generator.
// Assumes timerTick is a one-cycle pulse on sys_clk from the period timer.
`timescale 1ns/1ns
`default_nettype none
module spm_rate_gen (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic run,
  input wire spm_pkg::spm_rate_t rate,
  input wire logic timerTick,
  output logic halfTick
);
  import spm_pkg::*;

  logic [5:0] count;

  function automatic logic [5:0] halfLimit(input spm_rate_t sel);
    unique case (sel)
      RATE_DIV4: halfLimit = HALF_DIV4;
      RATE_DIV16: halfLimit = HALF_DIV16;
      RATE_DIV64: halfLimit = HALF_DIV64;
      RATE_TIMER: halfLimit = HALF_DIV4;
    endcase
  endfunction

  logic atLimit;
  assign atLimit = (count == halfLimit(rate) - 6'h01);

  always_ff @(posedge sys_clk) begin
    if (!resetn || !run || rate == RATE_TIMER || atLimit) begin
      count <= 6'h00;
    end else begin
      count <= count + 6'h01;
    end
  end

  // The timer rate toggles the clock once per timer pulse, giving timer output over two.
  assign halfTick = run && ((rate == RATE_TIMER) ? timerTick : atLimit);

endmodule
`default_nettype wire

// file: dv/spm_far_end.sv
// Behavioural far-side SPI device that can act as slave or as master.
// Assumes sckLine is the resolved clock wire and dataIn the core's resolved data-out wire.
`timescale 1ns/1ns
`default_nettype none
module spm_far_end (
  input wire logic sckLine,
  input wire logic dataIn,
  input wire logic actAsMaster,
  output logic dataOut,
  output logic sckDrive,
  output logic selectN
);
  logic [7:0] txByte;
  logic [7:0] rxByte;
  initial begin
    dataOut = 1'b0;
    sckDrive = 1'b0;
    selectN = 1'b1;
    txByte = 8'h00;
    rxByte = 8'h00;
  end
  task automatic load(input logic [7:0] b);
    txByte = b;
    dataOut = b[7];
  endtask
  // Slave role latches on the rising edge and shifts on the falling edge.
  always @(posedge sckLine) if (!actAsMaster) rxByte <= {rxByte[6:0], dataIn};
  always @(negedge sckLine) if (!actAsMaster) begin
    txByte = {txByte[6:0], 1'b0};
    dataOut = txByte[7];
  end
  // Master role changes data on the leading edge; the clock stands still between frames.
  task automatic xfer(input int half);
    selectN = 1'b0;
    #(half);
    for (int i = 0; i < 8; i++) begin
      sckDrive = 1'b1;
      dataOut = txByte[7 - i];
      #(half);
      rxByte = {rxByte[6:0], dataIn};
      sckDrive = 1'b0;
      #(half);
    end
    selectN = 1'b1;
    dataOut = ~dataOut;
  endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the SPI mode serial port core.
// Assumes the far-side model in spm_far_end and a 100 MHz core clock.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import spm_pkg::*;
  logic sys_clk, resetn, bufWrite, bufRead, collisionClear, irqClear, timerTick;
  logic [7:0] bufWriteData, bufReadData, tx, rx;
  spm_ctrl_t ctrl;
  spm_dir_t dirBits;
  logic writeCollisionFlag, bufferFullFlag, portIrqFlag, wakeRequest, portActive;
  logic sckOut, sckOe, sdoOut, sdoOe, farData, farSck, farSel, farMaster, sckLine, sdoLine;
  logic [31:0] lfsr;
  int mismatches, checked, tickCnt;
  time t0;
  logic [3:0] modes [4] = '{MODE_MASTER_DIV4, MODE_MASTER_DIV16, MODE_MASTER_DIV64,
    MODE_MASTER_TIMER};
  int periods [4] = '{2 * HALF_DIV4, 2 * HALF_DIV16, 2 * HALF_DIV64, 10};
  assign sckLine = sckOe ? sckOut : farSck;
  // A released data-out line shows the inverse of its last value.
  assign sdoLine = sdoOe ? sdoOut : ~sdoOut;
  spm_core #(.SS_RESET_CYCLES(4)) uut (.sys_clk(sys_clk), .resetn(resetn), .ctrl(ctrl),
    .dirBits(dirBits), .bufWrite(bufWrite), .bufWriteData(bufWriteData), .bufRead(bufRead),
    .bufReadData(bufReadData), .collisionClear(collisionClear), .irqClear(irqClear),
    .timerTick(timerTick), .writeCollisionFlag(writeCollisionFlag),
    .bufferFullFlag(bufferFullFlag), .portIrqFlag(portIrqFlag), .wakeRequest(wakeRequest),
    .portActive(portActive), .sckIn(sckLine), .sckOut(sckOut), .sckOe(sckOe),
    .sdiIn(farData), .sdoOut(sdoOut), .sdoOe(sdoOe), .ssNIn(farSel));
  spm_far_end far (.sckLine(sckLine), .dataIn(sdoLine), .actAsMaster(farMaster),
    .dataOut(farData), .sckDrive(farSck), .selectN(farSel));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    tickCnt <= (tickCnt == 4) ? 0 : tickCnt + 1;
    timerTick <= (tickCnt == 4);
  end
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic strobe(input int which, input logic [7:0] d);
    @(posedge sys_clk);
    bufWriteData <= d;
    bufWrite <= (which == 0);
    bufRead <= (which == 1);
    collisionClear <= (which == 2);
    irqClear <= (which == 3);
    @(posedge sys_clk);
    {bufWrite, bufRead, collisionClear, irqClear} <= 4'h0;
    repeat (2) @(posedge sys_clk);
  endtask
  // Software disables the port before reconfiguring it, then enables it again.
  task automatic cfg(input logic [3:0] m, input logic pol, input logic es, input logic [3:0] d);
    @(posedge sys_clk);
    ctrl.enable <= 1'b0;
    @(posedge sys_clk);
    ctrl <= '{enable: 1'b0, idlePolarity: pol, edgeSelect: es, modeField: m};
    dirBits <= spm_dir_t'(d);
    @(posedge sys_clk);
    ctrl.enable <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic wait_irq();
    for (int n = 0; n < 3000 && portIrqFlag !== 1'b1; n++) @(posedge sys_clk);
    check("irq", portIrqFlag, 1);
    check("wake", wakeRequest, 1);
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    stop_test();
  end
  initial begin
    {resetn, bufWrite, bufRead, collisionClear, irqClear, timerTick, farMaster} = 7'h00;
    ctrl = '0;
    dirBits = '0;
    bufWriteData = 8'h00;
    tickCnt = 0;
    lfsr = 32'hF77F23A7;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    check("flags after reset", {writeCollisionFlag, bufferFullFlag, portIrqFlag}, 0);
    for (int r = 0; r < 4; r++) begin
      cfg(modes[r], 1'b0, 1'b1, 4'b0100);
      lfsr = next_rand(lfsr);
      tx = lfsr[7:0];
      rx = lfsr[15:8];
      far.load(rx);
      strobe(0, tx);
      @(posedge sckOut);
      t0 = $time;
      @(posedge sckOut);
      check("bit period", ($time - t0) / 10, periods[r]);
      strobe(0, ~tx);
      check("collision", writeCollisionFlag, 1);
      wait_irq();
      check("received byte", bufReadData, rx);
      check("sent byte", far.rxByte, tx);
      check("full", bufferFullFlag, 1);
      strobe(1, 8'h00);
      check("full cleared", bufferFullFlag, 0);
      strobe(2, 8'h00);
      strobe(3, 8'h00);
      check("flags cleared", {writeCollisionFlag, portIrqFlag}, 0);
    end
    cfg(MODE_MASTER_DIV4, 1'b1, 1'b1, 4'b0100);
    check("idle clock high", sckOut, 1);
    cfg(MODE_MASTER_DIV4, 1'b0, 1'b1, 4'b0110);
    check("data-out released", sdoOe, 0);
    cfg(MODE_MASTER_DIV16, 1'b0, 1'b1, 4'b1100);
    far.load(8'hFF);
    check("clock not driven", sckOe, 0);
    wait_irq();
    check("monitor byte", bufReadData, 8'hFF);
    strobe(3, 8'h00);
    ctrl.enable <= 1'b0;
    strobe(0, 8'h5A);
    repeat (100) @(posedge sys_clk);
    check("disabled", {portActive, sdoOe, portIrqFlag, writeCollisionFlag}, 0);
    // Slave with edge select set would need select control, so edge select is 0 here.
    cfg(MODE_SLAVE_FREE, 1'b0, 1'b0, 4'b1101);
    farMaster = 1'b1;
    lfsr = next_rand(lfsr);
    tx = lfsr[7:0];
    rx = lfsr[15:8];
    strobe(0, tx);
    far.load(rx);
    far.xfer(80);
    wait_irq();
    check("slave received", bufReadData, rx);
    check("slave sent", far.rxByte, tx);
    check("select ignored", sdoOe, 1);
    cfg(MODE_SLAVE_SELECT, 1'b0, 1'b1, 4'b1101);
    check("select high releases", sdoOe, 0);
    far.selectN = 1'b0;
    repeat (4) @(posedge sys_clk);
    check("select low drives", sdoOe, 1);
    // Three clock pulses leave the slave mid-byte; a short select-high pulse must keep it there.
    repeat (3) begin
      far.sckDrive = 1'b1;
      #80;
      far.sckDrive = 1'b0;
      #80;
    end
    far.selectN = 1'b1;
    #20;
    far.selectN = 1'b0;
    repeat (4) @(posedge sys_clk);
    strobe(0, 8'h00);
    check("resumed mid-byte", writeCollisionFlag, 1);
    strobe(2, 8'h00);
    // A long select-high period resets the bit position, so the next write is accepted.
    far.selectN = 1'b1;
    repeat (12) @(posedge sys_clk);
    far.selectN = 1'b0;
    repeat (4) @(posedge sys_clk);
    strobe(0, 8'hC3);
    check("select reset", writeCollisionFlag, 0);
    check("write after reset", bufReadData, 8'hC3);
    stop_test();
  end
endmodule
`default_nettype wire
